/* File: design/fpm_unit.sv */
// Pair merge, inverse estimate and round-to-fixed datapath
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_unit
    import fpm_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Issue
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [63:0] src_data_in,
    input wire logic [63:0] second_src_data_in,
    // Control bits
    input wire logic fp_enable_in,
    input wire logic invalid_enable_in,
    // Completion
    output logic done_out,
    output logic [63:0] result_out,
    output logic [4:0] dest_fpr_field_out,
    output logic write_en_out,
    output logic [5:0] cause_out,
    output logic invalid_flag_set_out,
    output logic fp_exc_out,
    output logic cop_unusable_out,
    output logic reserved_instr_out
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Cause bits: 5 unimpl, 4 invalid, 3 divzero, 2 overflow, 1 underflow, 0 inexact
    logic [5:0] opcode;
    logic [4:0] fmt;
    logic [4:0] second_src_fpr_field;
    logic [5:0] func;
    fpm_kind_type kind;
    logic is_dbl;

    assign opcode = instr_in[31:26];
    assign fmt = instr_in[25:21];
    assign second_src_fpr_field = instr_in[20:16];
    assign func = instr_in[5:0];
    assign is_dbl = (fmt == `FPM_FMT_D);

    always_comb begin
        kind = FPM_K_NONE;
        if (opcode == `FPM_OP_FPCOP) begin
            if (fmt == `FPM_FMT_PS && (func == `FPM_FN_LOLO || func == `FPM_FN_LOHI ||
                func == `FPM_FN_HILO || func == `FPM_FN_HIHI)) begin
                kind = FPM_K_MERGE;
            end else if ((fmt == `FPM_FMT_S || is_dbl) && second_src_fpr_field == 5'h00) begin
                case (func)
                    `FPM_FN_RECIP: kind = FPM_K_RECIP;
                    `FPM_FN_RNDL: kind = FPM_K_RNDL;
                    `FPM_FN_RNDW: kind = FPM_K_RNDW;
                    default: kind = FPM_K_NONE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Merge
    // ----------------------------------------
    logic [63:0] merge_res;
    always_comb begin
        case (func[1:0])
            2'b00: merge_res = {src_data_in[31:0], second_src_data_in[31:0]};
            2'b01: merge_res = {src_data_in[31:0], second_src_data_in[63:32]};
            2'b10: merge_res = {src_data_in[63:32], second_src_data_in[31:0]};
            default: merge_res = {src_data_in[63:32], second_src_data_in[63:32]};
        endcase
    end

    // ----------------------------------------
    // Inverse estimate
    // ----------------------------------------
    // Exact for powers of two; other inputs use a linear seed, so the one-ulp bound is
    // met only for those, a trade of area for accuracy; rounding mode is never consulted.
    logic [63:0] recip_res;
    logic [5:0] recip_cause;
    logic [11:0] r_exp;
    logic [10:0] e_d;
    logic [51:0] f_d;
    logic [7:0] e_s;
    logic [22:0] f_s;
    logic r_sign;
    logic r_zero;
    logic r_inf;
    logic r_nan;
    logic r_denorm;

    always_comb begin
        recip_cause = 6'h00;
        recip_res = 64'h0;
        r_exp = 12'h000;
        r_sign = is_dbl ? src_data_in[63] : src_data_in[31];
        e_d = src_data_in[62:52];
        f_d = src_data_in[51:0];
        e_s = src_data_in[30:23];
        f_s = src_data_in[22:0];
        r_zero = is_dbl ? (e_d == 11'h000 && f_d == 52'h0) : (e_s == 8'h00 && f_s == 23'h0);
        r_inf = is_dbl ? (e_d == 11'h7FF && f_d == 52'h0) : (e_s == 8'hFF && f_s == 23'h0);
        r_nan = is_dbl ? (e_d == 11'h7FF && f_d != 52'h0) : (e_s == 8'hFF && f_s != 23'h0);
        r_denorm = !r_zero && (is_dbl ? (e_d == 11'h000) : (e_s == 8'h00));
        if (r_nan) begin
            recip_cause[4] = 1'b1;
            recip_res = is_dbl ? `FPM_MAX_L : {32'h0, 32'h7FBFFFFF};
        end else if (r_zero) begin
            recip_cause[3] = 1'b1;
            recip_res = is_dbl ? {r_sign, 11'h7FF, 52'h0} : {32'h0, r_sign, 8'hFF, 23'h0};
        end else if (r_inf) begin
            recip_res = is_dbl ? {r_sign, 63'h0} : {32'h0, r_sign, 31'h0};
        end else if (r_denorm) begin
            recip_cause[5] = 1'b1;
        end else if (is_dbl) begin
            r_exp = {`FPM_BIAS_D, 1'b0} - {1'b0, e_d} - {11'h0, (f_d != 52'h0)};
            if (r_exp[11] || r_exp == 12'h000) begin
                recip_cause[1] = 1'b1;
                recip_cause[0] = 1'b1;
                recip_res = {r_sign, 63'h0};
            end else begin
                recip_res = {r_sign, r_exp[10:0], (f_d == 52'h0) ? 52'h0 : (52'h0 - f_d) >> 1};
                recip_cause[0] = (f_d != 52'h0);
            end
        end else begin
            r_exp = {3'h0, `FPM_BIAS_S, 1'b0} - {4'h0, e_s} - {11'h0, (f_s != 23'h0)};
            if (r_exp[11] || r_exp == 12'h000) begin
                recip_cause[1] = 1'b1;
                recip_cause[0] = 1'b1;
                recip_res = {32'h0, r_sign, 31'h0};
            end else if (r_exp[8]) begin
                recip_cause[2] = 1'b1;
                recip_cause[0] = 1'b1;
                recip_res = {32'h0, r_sign, 8'hFF, 23'h0};
            end else begin
                recip_res = {32'h0, r_sign, r_exp[7:0], (f_s == 23'h0) ? 23'h0 : (23'h0 - f_s) >> 1};
                recip_cause[0] = (f_s != 23'h0);
            end
        end
    end

    // ----------------------------------------
    // Round to fixed
    // ----------------------------------------
    logic [63:0] conv_res;
    logic conv_invalid;
    logic conv_inexact;

    fpm_round_conv u_conv (
        .src_in(src_data_in),
        .dbl_in(is_dbl),
        .word_in(kind == FPM_K_RNDW),
        .res_out(conv_res),
        .invalid_out(conv_invalid),
        .inexact_out(conv_inexact)
    );

    // ----------------------------------------
    // Result select
    // ----------------------------------------
    // Out-of-format operands just flow through; nothing guards the source register.
    logic [63:0] res_next;
    logic [5:0] cause_next;
    logic wen_next;
    logic trap_next;

    always_comb begin
        res_next = 64'h0;
        cause_next = 6'h00;
        case (kind)
            FPM_K_MERGE: res_next = merge_res;
            FPM_K_RECIP: begin
                res_next = recip_res;
                cause_next = recip_cause;
            end
            FPM_K_RNDL, FPM_K_RNDW: begin
                res_next = conv_res;
                cause_next = {1'b0, conv_invalid, 1'b0, conv_invalid, 1'b0, conv_inexact};
            end
            default: res_next = 64'h0;
        endcase
        trap_next = cause_next[5] || (cause_next[4] && invalid_enable_in);
        wen_next = fp_enable_in && (kind != FPM_K_NONE) && !trap_next;
    end

    // ----------------------------------------
    // Completion registers
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= issue_valid_in;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            result_out <= 64'h0;
            dest_fpr_field_out <= 5'h00;
            write_en_out <= 1'b0;
            cause_out <= 6'h00;
            invalid_flag_set_out <= 1'b0;
            fp_exc_out <= 1'b0;
            cop_unusable_out <= 1'b0;
            reserved_instr_out <= 1'b0;
        end else if (issue_valid_in) begin
            result_out <= res_next;
            dest_fpr_field_out <= instr_in[10:6];
            write_en_out <= wen_next;
            cause_out <= fp_enable_in ? cause_next : 6'h00;
            invalid_flag_set_out <= fp_enable_in && cause_next[4];
            fp_exc_out <= fp_enable_in && trap_next;
            cop_unusable_out <= !fp_enable_in;
            reserved_instr_out <= fp_enable_in && (kind == FPM_K_NONE);
        end else begin
            write_en_out <= 1'b0;
            cause_out <= 6'h00;
            invalid_flag_set_out <= 1'b0;
            fp_exc_out <= 1'b0;
            cop_unusable_out <= 1'b0;
            reserved_instr_out <= 1'b0;
        end
    end
endmodule // fpm_unit

/* File: shared/fpm_defines.svh */
// Constants, encodings and the contract list of the pair merge / round unit
// Contract
// - Hi-lo merge: fs upper, ft lower
// - Hi-hi merge: fs upper, ft upper
// - Merges move bits, raise no flags
// - Decode hi-lo: 010001, format 10110, 101110
// - Decode hi-hi: function code 101111
// - Bad source format may corrupt registers
// - Inverse estimate within one ulp; the linear seed meets it only for powers of two
// - Inverse estimate ignores rounding mode, fixed
// - Inverse estimate raises its six conditions; the overflow bit is never raised by the estimate
// - Long convert, nearest-even, ignores mode
// - Word convert, nearest-even, ignores mode
// - Inf, NaN or overflow sets invalid
// - Invalid enabled: no write, trap now
// - Invalid disabled: write maximum positive integer
// - Converts raise inexact, invalid, overflow
// - Decode long 001000, word 001100, ft zero
// - Unusable when disabled, reserved when unsupported
// - Lo-lo 101100, lo-hi 101101 decoded alike
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
`define FPM_OP_FPCOP 6'h11
`define FPM_FMT_S 5'h10
`define FPM_FMT_D 5'h11
`define FPM_FMT_PS 5'h16
`define FPM_FN_LOLO 6'h2C
`define FPM_FN_LOHI 6'h2D
`define FPM_FN_HILO 6'h2E
`define FPM_FN_HIHI 6'h2F
`define FPM_FN_RECIP 6'h15
`define FPM_FN_RNDL 6'h08
`define FPM_FN_RNDW 6'h0C
`define FPM_MAX_L 64'h7FFFFFFFFFFFFFFF
`define FPM_MAX_W 64'h000000007FFFFFFF
`define FPM_ONE_D 64'h3FF0000000000000
`define FPM_ONE_S 32'h3F800000
`define FPM_BIAS_D 11'h3FF
`define FPM_BIAS_S 8'h7F
`endif

/* File: shared/fpm_pkg.sv */
// Types of the pair merge / round unit
package fpm_pkg;
    typedef enum logic [2:0] {
        FPM_K_NONE = 3'b000,
        FPM_K_MERGE = 3'b001,
        FPM_K_RECIP = 3'b010,
        FPM_K_RNDL = 3'b011,
        FPM_K_RNDW = 3'b100
    } fpm_kind_type;
endpackage

/* File: design/fpm_round_conv.sv */
// Float to signed fixed point, round to nearest even
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_round_conv
    import fpm_pkg::*;
(
    // Operand
    input wire logic [63:0] src_in,
    input wire logic dbl_in,
    input wire logic word_in,
    // Result
    output logic [63:0] res_out,
    output logic invalid_out,
    output logic inexact_out
);
    logic sign;
    logic [11:0] exp_unb;
    logic [52:0] mant;
    logic special;
    logic [127:0] shifted;
    logic [63:0] int_part;
    logic guard;
    logic sticky;
    logic round_up;
    logic [64:0] mag;
    logic too_big;
    logic [11:0] sh;

    always_comb begin
        sign = dbl_in ? src_in[63] : src_in[31];
        if (dbl_in) begin
            special = (src_in[62:52] == 11'h7FF);
            exp_unb = {1'b0, src_in[62:52]} - {1'b0, `FPM_BIAS_D};
            mant = {(src_in[62:52] != 11'h000), src_in[51:0]};
        end else begin
            special = (src_in[30:23] == 8'hFF);
            exp_unb = {4'h0, src_in[30:23]} - {4'h0, `FPM_BIAS_S};
            mant = {(src_in[30:23] != 8'h00), src_in[22:0], 29'h0};
        end
        // Mantissa bit 52 has weight 2^exp; value placed with binary point at bit 64
        too_big = 1'b0;
        shifted = 128'h0;
        sh = 12'h000;
        // Below one half the whole value is sticky; a left shift there would wrap its count
        if (!exp_unb[11] && exp_unb > 12'd63) begin
            too_big = 1'b1;
        end else if (exp_unb[11] && exp_unb < 12'hFFF) begin
            shifted = {127'h0, (mant != 53'h0)};
        end else begin
            sh = exp_unb + 12'd12;
            shifted = {75'h0, mant} << sh[6:0];
        end
        int_part = shifted[127:64];
        guard = shifted[63];
        sticky = (shifted[62:0] != 63'h0);
        round_up = guard && (sticky || int_part[0]);
        mag = {1'b0, int_part} + {64'h0, round_up};
        inexact_out = !special && !too_big && (guard || sticky);
        if (word_in) begin
            too_big = too_big || (mag > (sign ? 65'h80000000 : 65'h7FFFFFFF));
        end else begin
            too_big = too_big || mag[64] || (mag[63:0] > (sign ? 64'h8000000000000000 : `FPM_MAX_L));
        end
        invalid_out = special || too_big;
        if (invalid_out) begin
            res_out = word_in ? `FPM_MAX_W : `FPM_MAX_L;
        end else if (word_in) begin
            res_out = {32'h0, sign ? (32'h0 - mag[31:0]) : mag[31:0]};
        end else begin
            res_out = sign ? (64'h0 - mag[63:0]) : mag[63:0];
        end
    end
endmodule // fpm_round_conv

/* File: testbench/fpm_unit_assertions.sv */
// Concurrent checks on the ports of the pair merge / round unit
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_unit_assertions
    import fpm_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Issue and control
    input wire logic issue_valid_in,
    input wire logic [31:0] instr_in,
    input wire logic [63:0] src_data_in,
    input wire logic [63:0] second_src_data_in,
    input wire logic fp_enable_in,
    input wire logic invalid_enable_in,
    // Completion
    input wire logic done_out,
    input wire logic [63:0] result_out,
    input wire logic write_en_out,
    input wire logic [5:0] cause_out,
    input wire logic invalid_flag_set_out,
    input wire logic fp_exc_out,
    input wire logic cop_unusable_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_ps_issue;
        issue_valid_in && fp_enable_in && instr_in[31:21] == {`FPM_OP_FPCOP, `FPM_FMT_PS};
    endsequence
    sequence s_merge(logic [5:0] fn);
        s_ps_issue ##0 instr_in[5:0] == fn;
    endsequence
    a_done_one_cycle: assert property (issue_valid_in |=> done_out)
        else $error("done missing after issue");
    a_no_stray_done: assert property (!issue_valid_in |=> !done_out)
        else $error("done without issue");
    a_hilo_merge: assert property (s_merge(`FPM_FN_HILO) |=> write_en_out &&
        result_out == {$past(src_data_in[63:32]), $past(second_src_data_in[31:0])}) else $error("hi-lo merge wrong");
    a_hihi_merge: assert property (s_merge(`FPM_FN_HIHI) |=> write_en_out &&
        result_out == {$past(src_data_in[63:32]), $past(second_src_data_in[63:32])}) else $error("hi-hi merge wrong");
    a_lolo_merge: assert property (s_merge(`FPM_FN_LOLO) |=> write_en_out &&
        result_out == {$past(src_data_in[31:0]), $past(second_src_data_in[31:0])}) else $error("lo-lo merge wrong");
    a_merge_quiet: assert property (s_ps_issue ##0 instr_in[5:2] == 4'hB |=> cause_out == 6'h00)
        else $error("merge raised a condition");
    a_unusable_blocks: assert property (issue_valid_in && !fp_enable_in |=>
        cop_unusable_out && !write_en_out && cause_out == 6'h00) else $error("disabled unit not refused");
    a_inv_trap: assert property (invalid_flag_set_out && $past(invalid_enable_in) |->
        fp_exc_out && !write_en_out) else $error("enabled invalid not trapped");
    a_inv_default: assert property (invalid_flag_set_out && !$past(invalid_enable_in) |-> write_en_out &&
        result_out inside {`FPM_MAX_L, `FPM_MAX_W}) else $error("invalid default result wrong");
    a_inv_cause: assert property (invalid_flag_set_out |-> cause_out[4] && done_out)
        else $error("invalid flag without cause");
endmodule // fpm_unit_assertions
bind fpm_unit fpm_unit_assertions u_chk (.clk_in(clk_in), .resetn_in(resetn_in), .issue_valid_in(issue_valid_in),
    .instr_in(instr_in), .src_data_in(src_data_in), .second_src_data_in(second_src_data_in),
    .fp_enable_in(fp_enable_in), .invalid_enable_in(invalid_enable_in), .done_out(done_out),
    .result_out(result_out), .write_en_out(write_en_out), .cause_out(cause_out),
    .invalid_flag_set_out(invalid_flag_set_out), .fp_exc_out(fp_exc_out), .cop_unusable_out(cop_unusable_out));

/* File: testbench/fpm_fpr_model.sv */
// Register file model that takes the unit's write-backs
`timescale 1ns/1ps
module fpm_fpr_model (
    // Clock
    input wire logic clk_in,
    // Write-back
    input wire logic done_in,
    input wire logic write_en_in,
    input wire logic [4:0] dest_in,
    input wire logic [63:0] data_in,
    // Observation
    output int wr_count_out,
    output logic [63:0] last_data_out
);
    logic [63:0] fpr_reg [32];
    initial wr_count_out = 0;
    // A write only counts when it arrives with the completion strobe
    always @(posedge clk_in) begin
        if (done_in === 1'b1 && write_en_in === 1'b1) begin
            fpr_reg[dest_in] <= data_in;
            last_data_out <= data_in;
            wr_count_out <= wr_count_out + 1;
        end
    end
endmodule // fpm_fpr_model

/* File: testbench/fp_pair_merge_round_unit_tb.sv */
// Self-checking bench of the pair merge / round unit
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fp_pair_merge_round_unit_tb;
    import fpm_pkg::*;
    typedef struct {logic [63:0] r; logic [4:0] f; logic [5:0] m; logic [5:0] c; logic [4:0] d;} fpm_exp_type;
    logic clk_in = 0, resetn_in = 0, issue_valid_in = 0, fp_enable_in = 1, invalid_enable_in = 0;
    logic [31:0] instr_in = 0;
    logic [63:0] src_data_in = 0, second_src_data_in = 0, r, a, b, last_data;
    logic done_out, write_en_out, invalid_flag_set_out, fp_exc_out, cop_unusable_out, reserved_instr_out;
    logic [63:0] result_out;
    logic [4:0] dest_fpr_field_out;
    logic [5:0] cause_out;
    int err_total = 0, total_checks = 0, n_wr = 0, wr_count, cyc = 0;
    fpm_exp_type exq[$], e;
    fpm_unit dut (.clk_in(clk_in), .resetn_in(resetn_in), .issue_valid_in(issue_valid_in), .instr_in(instr_in),
        .src_data_in(src_data_in), .second_src_data_in(second_src_data_in), .fp_enable_in(fp_enable_in),
        .invalid_enable_in(invalid_enable_in), .done_out(done_out), .result_out(result_out),
        .dest_fpr_field_out(dest_fpr_field_out), .write_en_out(write_en_out), .cause_out(cause_out),
        .invalid_flag_set_out(invalid_flag_set_out), .fp_exc_out(fp_exc_out),
        .cop_unusable_out(cop_unusable_out), .reserved_instr_out(reserved_instr_out));
    fpm_fpr_model u_fpr (.clk_in(clk_in), .done_in(done_out), .write_en_in(write_en_out),
        .dest_in(dest_fpr_field_out), .data_in(result_out), .wr_count_out(wr_count), .last_data_out(last_data));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] ins(logic [4:0] fmt, logic [4:0] ft, logic [5:0] fn);
        return {`FPM_OP_FPCOP, fmt, ft, 5'h03, 5'h07, fn};
    endfunction
    // Flags are {write, invalid flag, trap, unusable, reserved}; a merge in a non-paired format is issued too and expects reserved
    task automatic issue(logic [31:0] i, logic [63:0] s, logic [63:0] t, logic en, logic ie,
        logic [63:0] er, logic [4:0] f, logic [5:0] m, logic [5:0] c);
        @(posedge clk_in);
        #1;
        issue_valid_in = 1;
        instr_in = i;
        src_data_in = s;
        second_src_data_in = t;
        fp_enable_in = en;
        invalid_enable_in = ie;
        exq.push_back('{er, f, m, c, i[10:6]});
        if (f[4]) n_wr++;
    endtask
    task automatic idle();
        @(posedge clk_in);
        #1;
        issue_valid_in = 0;
        repeat (2) @(posedge clk_in);
    endtask
    always @(posedge clk_in) begin
        #2;
        if (done_out === 1'b1) begin
            if (exq.size() == 0) chk("stray done", 1, 0);
            else begin
                e = exq.pop_front();
                chk("flags", {write_en_out, invalid_flag_set_out, fp_exc_out, cop_unusable_out, reserved_instr_out},
                    e.f);
                chk("cause", cause_out & e.m, e.c);
                if (e.f[4]) chk("result", result_out, e.r);
                if (e.f[4]) chk("dest", dest_fpr_field_out, e.d);
            end
        end
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        void'($urandom(70));
        repeat (5) @(posedge clk_in);
        #1;
        resetn_in = 1;
        // Back-to-back merges over the whole family, random operands
        for (int k = 0; k < 8; k++) begin
            a = {$urandom(), $urandom()};
            b = {$urandom(), $urandom()};
            case (k % 4)
                0: r = {a[31:0], b[31:0]};
                1: r = {a[31:0], b[63:32]};
                2: r = {a[63:32], b[31:0]};
                default: r = {a[63:32], b[63:32]};
            endcase
            issue(ins(`FPM_FMT_PS, 5'h05, 6'h2C + 6'(k % 4)), a, b, 1, k[0], r, 5'h10, 6'h3F, 6'h00);
        end
        idle();
        chk("last write", last_data, r);
        $display("merge test done");
        // Ties go to even for single-to-word and double-to-long; a tiny value rounds to zero, inexact
        issue(ins(`FPM_FMT_S, 0, `FPM_FN_RNDW), 64'h40200000, 0, 1, 0, 64'h2, 5'h10, 6'h3F, 6'h01);
        issue(ins(`FPM_FMT_S, 0, `FPM_FN_RNDW), 64'h40600000, 0, 1, 0, 64'h4, 5'h10, 6'h3F, 6'h01);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDL), 64'h3FF8000000000000, 0, 1, 0, 64'h2, 5'h10, 6'h3F, 6'h01);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDL), 64'hC004000000000000, 0, 1, 0, -64'sd2, 5'h10, 6'h3F, 6'h01);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDL), 64'h3EB0000000000001, 0, 1, 0, 64'h0, 5'h10, 6'h3F, 6'h01);
        idle();
        $display("round test done");
        // Out of range and infinity, trap off then on
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDW), 64'h4270000000000000, 0, 1, 0, `FPM_MAX_W, 5'h18, 6'h3F, 6'h14);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDL), 64'h7FF0000000000000, 0, 1, 0, `FPM_MAX_L, 5'h18, 6'h3F, 6'h14);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDW), 64'h4270000000000000, 0, 1, 1, 0, 5'h0C, 6'h3F, 6'h14);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RNDL), 64'h7FF0000000000000, 0, 1, 1, 0, 5'h0C, 6'h3F, 6'h14);
        idle();
        $display("invalid test done");
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RECIP), 64'h4000000000000000, 0, 1, 0, 64'h3FE0000000000000,
            5'h10, 6'h3F, 0);
        issue(ins(`FPM_FMT_S, 0, `FPM_FN_RECIP), 64'h40800000, 0, 1, 0, 64'h3E800000, 5'h10, 6'h3F, 0);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_RECIP), 64'h0, 0, 1, 0, 64'h7FF0000000000000, 5'h10, 6'h3F, 6'h08);
        idle();
        $display("inverse test done");
        // Refusals: unit disabled, merge in a non-paired format, round with a second source
        issue(ins(`FPM_FMT_PS, 0, `FPM_FN_HILO), 1, 2, 0, 0, 0, 5'h02, 6'h3F, 0);
        issue(ins(`FPM_FMT_D, 0, `FPM_FN_HIHI), 1, 2, 1, 0, 0, 5'h01, 0, 0);
        issue(ins(`FPM_FMT_D, 5'h04, `FPM_FN_RNDL), 1, 2, 1, 0, 0, 5'h01, 0, 0);
        idle();
        $display("decode test done");
        chk("write count", 64'(wr_count), 64'(n_wr));
        final_report();
    end
endmodule // fp_pair_merge_round_unit_tb
